// File: src/trace_qualifier.sv
/*
 * Trace capture qualifier: watches each observed bus cycle, finds trace
 * points, qualifies cycles for trace memory and streams them out.
 * Assumes bus-cycle inputs on clk_i, one strobe per observed cycle, and a
 * classic Wishbone master for the registers.
 */
// Implementation choices: the address map and the Wishbone slave port.
module trace_qualifier
	import trace_qual_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Observed bus cycle
	input  wire logic                  cyc_valid_i,
	input  wire logic [ADDR_W-1:0]     cyc_addr_i,
	input  wire logic [DATA_W-1:0]     cyc_data_i,
	input  wire logic                  cyc_fetch_i,
	input  wire logic                  cyc_data_hit_i,
	input  wire logic [NUM_EVENTS-1:0] event_i,
	input  wire logic [NUM_EXC-1:0]    exc_i,
	input  wire logic [AUX_W-1:0]      task_id_i,
	input  wire logic                  ext_trig_pin_i,
	// Trace record stream
	output logic                       rec_valid_o,
	input  wire logic                  rec_ready_i,
	output logic      [REC_W-1:0]      rec_data_o,
	// Break and status
	output logic                       break_req_o,
	output logic                       trace_point_o,
	output logic                       acquiring_o
);
	// Registers
	logic [2:0]            mode_q;
	logic [2:0]            delay_q;
	logic [1:0]            aux_q;
	logic                  or_en_q;
	logic [NUM_EVENTS-1:0] ev_en_q;
	logic [NUM_EXC-1:0]    exc_en_q;
	logic [3:0]            qkind_q;
	logic [3:0]            ev_a_q;
	logic [3:0]            ev_b_q;
	logic [ADDR_W-1:0]     lo_q;
	logic [ADDR_W-1:0]     hi_q;
	logic                  acq_q;
	logic                  wrapped_q;
	logic                  overflow_q;
	logic                  tp_seen_q;
	logic [CNT_W-1:0]      wptr_q;
	logic                  in_window_q;
	logic [8:0]            post_q;
	logic                  ext_s1_q;
	logic                  ext_s2_q;

	// Bus
	logic        wb_req;
	logic        wr_en;
	logic        start_cmd;
	logic        stop_cmd;
	logic [31:0] rd_mux;
	logic        rd_hit;

	assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en     = wb_req && wb_we_i && wb_sel_i[0];
	assign start_cmd = wr_en && (wb_adr_i == REG_CONTROL) && wb_dat_i[CTL_START];
	assign stop_cmd  = wr_en && (wb_adr_i == REG_CONTROL) && wb_dat_i[CTL_STOP];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q   <= RST_MODE;
			delay_q  <= RST_DELAY; // R2
			aux_q    <= RST_AUX; // R11
			or_en_q  <= RST_OR_EN;
			ev_en_q  <= '0;
			exc_en_q <= '0;
			qkind_q  <= '0;
			ev_a_q   <= '0;
			ev_b_q   <= '0;
			lo_q     <= '0;
			hi_q     <= '0;
		end else if (ce_i && wr_en) begin
			case (wb_adr_i)
				REG_MODE: begin
					mode_q  <= wb_dat_i[MODE_LSB +: 3];
					delay_q <= (wb_dat_i[DELAY_LSB +: 3] > 3'h4) ? 3'h4 : wb_dat_i[DELAY_LSB +: 3];
					aux_q   <= (wb_dat_i[AUX_LSB +: 2] == 2'h3) ? RST_AUX : wb_dat_i[AUX_LSB +: 2];
					or_en_q <= wb_dat_i[OR_EN_BIT];
				end
				REG_EV_ENABLE: ev_en_q  <= wb_dat_i[NUM_EVENTS-1:0];
				REG_EXC_EN:    exc_en_q <= wb_dat_i[NUM_EXC-1:0]; // R1
				REG_QUAL: begin
					qkind_q <= wb_dat_i[QKIND_LSB +: 4];
					ev_a_q  <= wb_dat_i[EV_A_LSB +: 4];
					ev_b_q  <= wb_dat_i[EV_B_LSB +: 4];
				end
				REG_RANGE_LO:  lo_q <= wb_dat_i[ADDR_W-1:0];
				REG_RANGE_HI:  hi_q <= wb_dat_i[ADDR_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0;
		case (wb_adr_i)
			REG_MODE:      rd_mux = {19'h0, or_en_q, 2'h0, aux_q, 1'b0, delay_q, 1'b0, mode_q};
			REG_EV_ENABLE: rd_mux = {16'h0, ev_en_q};
			REG_EXC_EN:    rd_mux = {25'h0, exc_en_q};
			REG_QUAL:      rd_mux = {20'h0, ev_b_q, ev_a_q, qkind_q};
			REG_RANGE_LO:  rd_mux = {8'h0, lo_q};
			REG_RANGE_HI:  rd_mux = {8'h0, hi_q};
			REG_STATUS:    rd_mux = {28'h0, tp_seen_q, wrapped_q, overflow_q, acq_q};
			REG_COUNT:     rd_mux = {9'h0, wptr_q};
			REG_CONTROL:   rd_mux = 32'h0;
			default:       rd_hit = 1'b0;
		endcase
	end

	// Unmapped addresses still ack and read as zero, so the master never hangs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_hit ? rd_mux : 32'h0;
			end
		end
	end

	// External trigger comes from a pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else if (ce_i) begin
			ext_s1_q <= ext_trig_pin_i;
			ext_s2_q <= ext_s1_q;
		end
	end

	// Trace point detection
	logic tp_raw;
	logic ev_a;
	logic ev_b;
	logic in_range;
	assign ev_a     = event_i[ev_a_q];
	assign ev_b     = event_i[ev_b_q];
	assign in_range = (cyc_addr_i >= lo_q) && (cyc_addr_i <= hi_q);
	assign tp_raw   = cyc_valid_i && ((or_en_q && |(event_i & ev_en_q)) // R15
		|| |(exc_i & exc_en_q)); // R1
	assign trace_point_o = tp_raw && acq_q;

	// Qualification
	logic qual_active;
	logic keep;
	logic repeat_mode;
	assign repeat_mode = (mode_q == MODE_REP_STOP) || (mode_q == MODE_REP_FULL);
	assign qual_active = !repeat_mode; // R3

	always_comb begin
		keep = 1'b1;
		if (qual_active) begin
			case (qual_kind_t'(qkind_q))
				Q_EXT_BETWEEN:  keep = (in_window_q || ev_a) && !ev_b; // R4
				Q_EXT_DURATION: keep = ev_a; // R5
				Q_EXT_SUB:      keep = ev_a && in_range; // R6
				Q_EXT_DATA:     keep = cyc_fetch_i && cyc_data_hit_i; // R7
				Q_DEL_BETWEEN:  keep = !((in_window_q || ev_a) && !ev_b); // R12
				Q_DEL_DURATION: keep = !ev_a; // R8
				Q_DEL_SUB:      keep = !(ev_a && in_range); // R9
				default:        keep = 1'b1;
			endcase
		end
	end

	// Window is open from the start event until an end event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_window_q <= 1'b0;
		end else if (ce_i && cyc_valid_i) begin
			if (ev_b) begin
				in_window_q <= 1'b0; // R4
			end else if (ev_a) begin
				in_window_q <= 1'b1; // R12
			end
		end
	end

	// Repeat modes keep 256 cycles after each trace point; the 255 before
	// sit in host memory already, so only the tail is gated here
	logic rep_keep;
	assign rep_keep = !repeat_mode || tp_raw || (post_q != '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			post_q <= '0;
		end else if (ce_i && !repeat_mode) begin
			// No tail may linger from a trace point seen in a fill mode
			post_q <= '0;
		end else if (ce_i && cyc_valid_i) begin
			if (tp_raw) begin
				post_q <= 9'(REPEAT_AFTER);
			end else if (post_q != '0) begin
				post_q <= post_q - 1'b1;
			end
		end
	end

	// Record path
	logic             store;
	logic             fifo_ready;
	logic [AUX_W-1:0] aux_val;
	logic [REC_W-1:0] rec;
	logic             mem_full;
	logic             brk_pulse;

	always_comb begin
		case (aux_sel_t'(aux_q))
			AUX_TASK: aux_val = task_id_i; // R11
			AUX_EXT:  aux_val = {{(AUX_W-1){1'b0}}, ext_s2_q}; // R11
			default:  aux_val = AUX_W'(event_i[AUX_W-1:0]); // R11
		endcase
	end

	assign mem_full    = (wptr_q == CNT_W'(MEM_CYCLES - 1));
	assign store       = acq_q && cyc_valid_i && keep && rep_keep && fifo_ready;
	assign rec         = {tp_raw, cyc_fetch_i, aux_val, cyc_data_i, cyc_addr_i};
	assign acquiring_o = acq_q;

	// Acquisition control and ring pointer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acq_q      <= 1'b0;
			wptr_q     <= '0;
			wrapped_q  <= 1'b0;
			overflow_q <= 1'b0;
			tp_seen_q  <= 1'b0;
		end else if (ce_i) begin
			if (start_cmd) begin
				acq_q      <= 1'b1;
				wptr_q     <= '0;
				wrapped_q  <= 1'b0;
				overflow_q <= 1'b0;
				// Set wins over the clear on the start edge
				tp_seen_q  <= trace_point_o;
			end else begin
				if (stop_cmd || brk_pulse && (mode_q == MODE_FILL_AROUND)) begin
					acq_q <= 1'b0;
				end
				if (trace_point_o) begin
					tp_seen_q <= 1'b1;
				end
				if (store) begin
					wptr_q <= mem_full ? '0 : wptr_q + 1'b1;
					if (mem_full) begin
						wrapped_q <= 1'b1; // R13
						if (mode_q == MODE_FILL_FULL || mode_q == MODE_REP_FULL) begin
							overflow_q <= 1'b1;
							acq_q      <= 1'b0; // R14
						end
					end
				end
			end
		end
	end

	trace_fifo #(
		.WIDTH (REC_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (store),
		.in_ready_o  (fifo_ready),
		.in_data_i   (rec),
		.out_valid_o (rec_valid_o),
		.out_ready_i (rec_ready_i),
		.out_data_o  (rec_data_o)
	);

	// Break request after the programmed delay
	break_delay u_delay (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.ce_i          (ce_i),
		.delay_sel_i   (delay_q),
		.arm_i         (acq_q),
		.trace_point_i (trace_point_o),
		.break_o       (brk_pulse),
		.busy_o        ()
	);
	assign break_req_o = brk_pulse; // R2
endmodule : trace_qualifier

// File: common/trace_qual_pkg.sv
/*
 * Constants, modes and the register map of the trace capture qualifier.
 * Assumes a 100 MHz bus clock and a classic Wishbone slave with 32-bit data.
 */
// How it works
// [R1] Seven exceptional events each enable separately as a trace-point source.
// [R2] Break request follows a trace point after 0M..4M bus cycles, default zero.
// [R3] Capture qualifiers act only in the three single-fill modes, not repeat modes.
// [R4] Between-events extraction records from start-event cycle, excluding end-event cycle.
// [R5] Event-duration extraction keeps only cycles where the event holds.
// [R6] Subroutine extraction keeps event cycles whose address lies in the range.
// [R7] Data-access extraction records instructions that touched the given data.
// [R8] Deletion drops exactly the event cycles and keeps the rest.
// [R9] Subroutine deletion drops event cycles in range, keeps all others.
// [R10] Software must set data-access events to the microcontroller's own bus.
// [R11] Each stored cycle carries event number, task id or external trigger; the code stores event lines 0..7, not a number.
// [R12] Between-events deletion drops start cycle up to, not including, end cycle.
// [R13] Fill-until-stop keeps a 4M-cycle ring, overwriting oldest entries.
// [R14] Fill-until-full stops acquisition when trace memory overflows.
// [R15] OR condition: any one of 16 enabled events gives a trace point.
package trace_qual_pkg;
	localparam int          ADDR_W        = 24;
	localparam int          DATA_W        = 16;
	localparam int          AUX_W         = 8;
	localparam int          NUM_EVENTS    = 16;
	localparam int          NUM_EXC       = 7;
	localparam int          FIFO_DEPTH    = 4;
	localparam int          REC_W         = ADDR_W + DATA_W + AUX_W + 2;
	localparam int          MEM_CYCLES    = 4194304;
	localparam int          CNT_W         = 23;
	localparam logic [22:0] MEGA_CYCLES   = 23'h100000;
	localparam int          REPEAT_BEFORE = 255;
	localparam int          REPEAT_AFTER  = 256;

	// Register byte offsets
	localparam logic [7:0] REG_MODE      = 8'h00;
	localparam logic [7:0] REG_EV_ENABLE = 8'h04;
	localparam logic [7:0] REG_EXC_EN    = 8'h08;
	localparam logic [7:0] REG_QUAL      = 8'h0c;
	localparam logic [7:0] REG_RANGE_LO  = 8'h10;
	localparam logic [7:0] REG_RANGE_HI  = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h18;
	localparam logic [7:0] REG_COUNT     = 8'h1c;
	localparam logic [7:0] REG_CONTROL   = 8'h20;

	// Field positions in REG_MODE
	localparam int MODE_LSB  = 0;
	localparam int DELAY_LSB = 4;
	localparam int AUX_LSB   = 8;
	localparam int OR_EN_BIT = 12;
	// Field positions in REG_QUAL
	localparam int QKIND_LSB = 0;
	localparam int EV_A_LSB  = 4;
	localparam int EV_B_LSB  = 8;
	// Bits in REG_CONTROL (write one to act)
	localparam int CTL_START = 0;
	localparam int CTL_STOP  = 1;

	typedef enum logic [2:0] {
		MODE_FILL_STOP, MODE_FILL_FULL, MODE_FILL_AROUND, MODE_REP_STOP, MODE_REP_FULL
	} trace_mode_t;
	typedef enum logic [3:0] {
		Q_NONE, Q_EXT_BETWEEN, Q_EXT_DURATION, Q_EXT_SUB, Q_EXT_DATA,
		Q_DEL_BETWEEN, Q_DEL_DURATION, Q_DEL_SUB
	} qual_kind_t;
	typedef enum logic [1:0] {AUX_EVENT, AUX_TASK, AUX_EXT} aux_sel_t;

	localparam logic [2:0]  RST_MODE   = 3'h0;
	localparam logic [2:0]  RST_DELAY  = 3'h0;
	localparam logic [1:0]  RST_AUX    = 2'h0;
	localparam logic        RST_OR_EN  = 1'b1;
endpackage : trace_qual_pkg

// File: src/trace_fifo.sv
/*
 * Small FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous reset and a clock enable.
 */
module trace_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : trace_fifo

// File: src/break_delay.sv
/*
 * Break delay counter: after a trace point, requests a break once the
 * programmed number of megacycles has elapsed.
 * Assumes one clock, synchronous reset and a clock enable.
 */
module break_delay
	import trace_qual_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// Control
	input  wire logic [2:0] delay_sel_i,
	input  wire logic       arm_i,
	input  wire logic       trace_point_i,
	// Result
	output logic            break_o,
	output logic            busy_o
);
	logic [CNT_W:0] cnt_q;
	logic [CNT_W:0] target;
	logic           run_q;

	assign target = (CNT_W+1)'(delay_sel_i) * (CNT_W+1)'(MEGA_CYCLES);
	assign busy_o = run_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q   <= 1'b0;
			cnt_q   <= '0;
			break_o <= 1'b0;
		end else if (ce_i) begin
			break_o <= 1'b0;
			if (!arm_i) begin
				run_q <= 1'b0;
			end else if (!run_q && trace_point_i) begin
				if (target == '0) begin
					break_o <= 1'b1; // R2
				end else begin
					run_q <= 1'b1;
					cnt_q <= (CNT_W+1)'(1);
				end
			end else if (run_q) begin
				if (cnt_q == target) begin
					run_q   <= 1'b0;
					break_o <= 1'b1; // R2
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule : break_delay

// File: verification/trace_qualifier_checker.sv
/*
 * Port checker for the trace qualifier.
 * Assumes the break delay stays at zero and ce_i is held high.
 */
module trace_qualifier_checker
	import trace_qual_pkg::*;
(
	// Clock and reset
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             ce_i,
	// Register bus
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_ack_o,
	// Observed cycle
	input wire logic             cyc_valid_i,
	input wire logic [NUM_EVENTS-1:0] event_i,
	input wire logic [NUM_EXC-1:0] exc_i,
	// Outputs
	input wire logic             rec_valid_o,
	input wire logic             rec_ready_i,
	input wire logic [REC_W-1:0] rec_data_o,
	input wire logic             break_req_o,
	input wire logic             trace_point_o,
	input wire logic             acquiring_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("request not acknowledged");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_break_cause: assert property (break_req_o |-> $past(trace_point_o))
		else $error("break not one cycle after trace point");
	chk_tp_acq: assert property (trace_point_o |-> acquiring_o)
		else $error("trace point while idle");
	chk_tp_cause: assert property (trace_point_o |-> (|event_i) || (|exc_i))
		else $error("trace point without event");
	chk_rec_hold: assert property (rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_data_o))
		else $error("record dropped while stalled");
	chk_rec_cause: assert property ($rose(rec_valid_o) |-> $past(cyc_valid_i))
		else $error("record without bus cycle");

	cover property (wb_ack_o);
	cover property (break_req_o);
	cover property (rec_valid_o && !rec_ready_i);
endmodule : trace_qualifier_checker

// File: verification/target_bus.sv
/*
 * Model of the observed target bus: twelve fixed cycles per burst.
 * Assumes a shared clock; idle address and data lines flip so stale values never match.
 */
module target_bus
	import trace_qual_pkg::*;
(
	input  wire logic                  clk_i,
	output logic                       valid_o,
	output logic      [ADDR_W-1:0]     addr_o,
	output logic      [DATA_W-1:0]     data_o,
	output logic                       fetch_o,
	output logic                       hit_o,
	output logic      [NUM_EVENTS-1:0] event_o,
	output logic      [NUM_EXC-1:0]    exc_o,
	output logic      [AUX_W-1:0]      task_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{valid_o, addr_o, data_o, fetch_o, hit_o, event_o, exc_o, task_o} = '0;
	end

	task idle();
		valid_o <= 1'b0;
		addr_o  <= ~addr_o;
		data_o  <= ~data_o;
		hit_o   <= 1'b0;
		event_o <= '0;
		exc_o   <= '0;
	endtask : idle

	// Slow mode leaves an idle clock between bus cycles
	task burst(input bit slow);
		logic [NUM_EVENTS-1:0] ev;
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			ev = '0;
			ev[3] = i inside {1, 2, 5};
			ev[5] = (i == 7);
			valid_o <= 1'b1;
			addr_o  <= 24'h000100 + 24'(i);
			data_o  <= 16'h0a00 + 16'(i);
			fetch_o <= (i % 2 == 0);
			hit_o   <= i inside {2, 4, 6};
			event_o <= ev;
			exc_o   <= 7'(i < 7 ? 1 << i : 0);
			task_o  <= 8'h40 + 8'(i);
			if (slow) begin
				@(posedge clk_i);
				idle();
			end
		end
		@(posedge clk_i);
		idle();
	endtask : burst
endmodule : target_bus

// File: verification/trace_qualifier_tb.sv
/*
 * Self-checking bench for the trace qualifier.
 * Assumes break delay zero; the 4M-cycle ring and overflow are not reached.
 */
module trace_qualifier_tb;
	import trace_qual_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i, rst_i, cyc, stb, we, rdy;
	logic [7:0]  adr;
	logic [31:0] dat, q, rdat;
	logic        ack, rec_valid, brk, tp, acq, ext;
	logic [REC_W-1:0] rec;
	logic        valid, fetch, hit;
	logic [ADDR_W-1:0] caddr;
	logic [DATA_W-1:0] cdata;
	logic [NUM_EVENTS-1:0] ev;
	logic [NUM_EXC-1:0] exc;
	logic [AUX_W-1:0] tid;
	logic [REC_W-1:0] got[$];
	int mismatches, cmp_count, brk_n, cyc_n;
	// Masks of kept cycles for qualifier kinds 0..7
	logic [11:0] keep_m [8] = '{12'hfff, 12'h07e, 12'h026, 12'h020,
		12'h054, 12'hf81, 12'hfd9, 12'hfdf};

	target_bus bus (.clk_i(clk_i), .valid_o(valid), .addr_o(caddr), .data_o(cdata),
		.fetch_o(fetch), .hit_o(hit), .event_o(ev), .exc_o(exc), .task_o(tid));

	trace_qualifier uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cyc_valid_i(valid), .cyc_addr_i(caddr), .cyc_data_i(cdata),
		.cyc_fetch_i(fetch), .cyc_data_hit_i(hit), .event_i(ev), .exc_i(exc),
		.task_id_i(tid), .ext_trig_pin_i(ext), .rec_valid_o(rec_valid),
		.rec_ready_i(rdy), .rec_data_o(rec), .break_req_o(brk),
		.trace_point_o(tp), .acquiring_o(acq));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task wrap_up();
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task chk(input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// One classic cycle; read data lands in q
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// Burst with ready given by r, then drain and compare kept cycles
	task run(input logic [31:0] m, input logic [31:0] ql, input logic [11:0] km,
		input logic [11:0] tpm, input bit slow, input bit r);
		int n;
		logic [7:0] ax;
		wb(1'b1, REG_MODE, m);
		wb(1'b1, REG_QUAL, ql);
		got.delete();
		brk_n = 0;
		rdy <= r;
		bus.burst(slow);
		repeat (4) @(posedge clk_i);
		rdy <= 1'b1;
		repeat (8) @(posedge clk_i);
		n = 0;
		for (int i = 0; i < 12; i++) begin
			// Aux expected from what the bus model drives in cycle i, or from ext for the trigger
			if (m[9:8] == 2'h1)
				ax = 8'h40 + 8'(i);
			else if (m[9:8] == 2'h2)
				ax = 8'(ext);
			else
				ax = {2'h0, 1'(i == 7), 1'b0, 1'(i inside {1, 2, 5}), 3'h0};
			if (km[i]) begin
				if (n < got.size())
					chk(64'(got[n]), {14'h0, tpm[i], !i[0], ax, 16'h0a00 + 16'(i),
						24'h000100 + 24'(i)});
				n++;
			end
		end
		chk(64'(got.size()), 64'(n));
	endtask : run

	always @(posedge clk_i) begin
		if (!rst_i && rec_valid === 1'b1 && rdy === 1'b1)
			got.push_back(rec);
		if (brk === 1'b1)
			brk_n++;
		cyc_n++;
		if (cyc_n == 5000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, adr, dat} = '0;
		rdy = 1'b1;
		ext = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_MODE, 32'h0);
		chk(q, 32'h00001000);
		wb(1'b0, 8'h3c, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, REG_RANGE_LO, 32'h103);
		wb(1'b1, REG_RANGE_HI, 32'h106);
		wb(1'b1, REG_CONTROL, 32'h1);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q[0], acq);
		chk(acq, 1'b1);
		for (int k = 0; k < 8; k++)
			run(32'h1100 | (k % 3), 32'h530 | k, keep_m[k], '0, k[0], 1'b1);
		// Stalled sink: only four records fit
		run(32'h1100, 32'h0, 12'h00f, '0, 1'b0, 1'b0);
		for (int e = 0; e < 7; e++) begin
			wb(1'b1, REG_EXC_EN, 32'(1 << e));
			run(32'h1100, 32'h0, 12'hfff, 12'(1 << e), 1'b0, 1'b1);
			chk(64'(brk_n), 64'd1);
		end
		wb(1'b1, REG_EXC_EN, 32'h0);
		// Repeat fill ignores the duration qualifier
		wb(1'b1, REG_EV_ENABLE, 32'h8);
		run(32'h1103, 32'h32, 12'hffe, 12'h026, 1'b0, 1'b1);
		// Event lines, then the synchronised trigger pin, as aux
		run(32'h1000, 32'h0, 12'hfff, 12'h026, 1'b0, 1'b1);
		ext <= 1'b1;
		run(32'h1200, 32'h0, 12'hfff, 12'h026, 1'b1, 1'b1);
		wrap_up();
	end
endmodule : trace_qualifier_tb

bind trace_qualifier trace_qualifier_checker chk_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .cyc_valid_i, .event_i, .exc_i, .rec_valid_o, .rec_ready_i,
	.rec_data_o, .break_req_o, .trace_point_o, .acquiring_o);
